// ### hdl/adc_burst_map.vh
// Register map, field positions, reset values and timing counts for the burst controller
`ifndef ADC_BURST_MAP_VH
`define ADC_BURST_MAP_VH

`define ACC_CFG_ADDR 8'hba
`define PWR_TIME_ADDR 8'hbb
`define TRK_TIME_ADDR 8'hbc
`define RES_LOW_ADDR 8'hbd
`define RES_HIGH_ADDR 8'hbe

`define ACC_CFG_RESET 8'h00
`define PWR_TIME_RESET 8'h0f
`define TRK_TIME_RESET 8'h1e

`define TWELVE_BIT_POS 7
`define ACC_EN_POS 6
`define SJ_MSB 5
`define SJ_LSB 3
`define RPT_MSB 2
`define RPT_LSB 0
`define LP_POS 7
`define PWR_MSB 3
`define PWR_LSB 0
`define TRK_MSB 5
`define TRK_LSB 0

`define SJ_RIGHT0 3'h0
`define SJ_RIGHT1 3'h1
`define SJ_RIGHT2 3'h2
`define SJ_RIGHT3 3'h3
`define SJ_LEFT 3'h4

`define RPT_X1 3'h0
`define RPT_X4 3'h1
`define RPT_X8 3'h2
`define RPT_X16 3'h3
`define RPT_X32 3'h4
`define RPT_X64 3'h5

`define CLK_PERIOD_NS 50
`define PWRUP_UNIT_NS 400
`define PWRUP_UNIT_CYC (`PWRUP_UNIT_NS / `CLK_PERIOD_NS)
`define TRACK_UNIT_NS 50
`define TRACK_UNIT_CYC (`TRACK_UNIT_NS / `CLK_PERIOD_NS)
`define TRACK_BASE 64
`define TM_EXTRA_SAR 2'h3

`endif

// ### hdl/result_formatter.v
// Shift and justify formatting of the accumulator for read-back
`timescale 1ns/1ps
`include "adc_burst_map.vh"

module result_formatter (
  input wire [15:0] acc,
  input wire [2:0] shift_justify_select,
  input wire twelve_bit_enable,
  output reg [15:0] formatted
);

  always @* begin
    formatted = acc;
    case (shift_justify_select)
      `SJ_RIGHT0: formatted = acc;
      `SJ_RIGHT1: formatted = acc >> 1;
      `SJ_RIGHT2: formatted = acc >> 2;
      `SJ_RIGHT3: formatted = acc >> 3;
      // Left justify aligns a single sample's MSB with bit 15
      `SJ_LEFT: formatted = twelve_bit_enable ? (acc << 4) : (acc << 6);
      // Reserved codes read unshifted rather than garbage
      default: formatted = acc;
    endcase
  end

endmodule // result_formatter

// ### hdl/adc_burst_accumulate_control.v
// Burst sequencing, accumulation and register file of the converter control
`timescale 1ns/1ps
`include "adc_burst_map.vh"

module adc_burst_accumulate_control #(
  parameter RES_W = 12
) (
  input wire ref_clk,
  input wire rst_n,
  input wire [7:0] sfr_addr,
  input wire [7:0] sfr_wdata,
  input wire sfr_wr,
  input wire sfr_rd,
  output wire [7:0] sfr_rdata,
  input wire converter_enable,
  input wire burst_enable,
  input wire delayed_track_select,
  input wire start_conversion,
  input wire flag_clear,
  input wire sar_clk_en,
  input wire sar_done,
  input wire [RES_W-1:0] sar_result,
  output wire conversion_complete_flag,
  output wire sar_power_on,
  output wire sar_start,
  output wire twelve_bit_enable,
  output wire low_power_select,
  output wire busy
);

  localparam ST_IDLE = 3'd0;
  localparam ST_PWRUP = 3'd1;
  localparam ST_TRACK = 3'd2;
  localparam ST_TMDLY = 3'd3;
  localparam ST_CONV = 3'd4;

  ////////////////////////////////////////////////////////////////////////////
  // Registers

  reg twelve_ff;
  reg acc_en_ff;
  reg [2:0] sj_ff;
  reg [2:0] rpt_ff;
  reg lp_ff;
  reg [3:0] pwr_ff;
  reg [5:0] trk_ff;
  reg [15:0] acc_ff;
  reg [7:0] rdata_ff;
  reg flag_ff;
  reg [2:0] state_ff;
  reg [7:0] cnt_ff;
  reg [1:0] sar_cnt_ff;
  reg [6:0] remain_ff;
  reg start_ff;

  reg [2:0] nxt_state;
  reg [7:0] nxt_cnt;
  reg [1:0] nxt_sar_cnt;
  reg [6:0] nxt_remain;
  reg nxt_start;
  reg [15:0] nxt_acc;
  reg nxt_flag;
  reg [7:0] nxt_rdata;
  reg [6:0] burst_len;

  wire [15:0] formatted;
  wire [15:0] sample_ext;
  wire [31:0] pwrup_cycles;
  wire [31:0] track_cycles;
  wire wr_cfg;
  wire wr_pwr;
  wire wr_trk;
  wire wr_lo;
  wire wr_hi;
  wire conv_end;
  wire flag_set;

  assign wr_cfg = sfr_wr && (sfr_addr == `ACC_CFG_ADDR);
  assign wr_pwr = sfr_wr && (sfr_addr == `PWR_TIME_ADDR);
  assign wr_trk = sfr_wr && (sfr_addr == `TRK_TIME_ADDR);
  assign wr_lo = sfr_wr && (sfr_addr == `RES_LOW_ADDR);
  assign wr_hi = sfr_wr && (sfr_addr == `RES_HIGH_ADDR);

  assign pwrup_cycles = ({28'h0000000, pwr_ff} + 32'h00000001) * `PWRUP_UNIT_CYC;
  assign track_cycles = (`TRACK_BASE - {26'h0000000, trk_ff}) * `TRACK_UNIT_CYC;

  assign sample_ext = {{(16-RES_W){1'b0}}, sar_result};

  always @* begin
    burst_len = 7'h01;
    case (rpt_ff)
      `RPT_X1: burst_len = 7'h01;
      `RPT_X4: burst_len = 7'h04;
      `RPT_X8: burst_len = 7'h08;
      `RPT_X16: burst_len = 7'h10;
      `RPT_X32: burst_len = 7'h20;
      `RPT_X64: burst_len = 7'h40;
      // Reserved codes fall back to a single conversion
      default: burst_len = 7'h01;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Configuration registers

  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      twelve_ff <= 1'b0;
      acc_en_ff <= 1'b0;
      sj_ff <= 3'h0;
      rpt_ff <= 3'h0;
      lp_ff <= 1'b0;
      pwr_ff <= 4'hf;
      trk_ff <= 6'h1e;
    end else begin
      if (wr_cfg) begin
        twelve_ff <= sfr_wdata[`TWELVE_BIT_POS];
        acc_en_ff <= sfr_wdata[`ACC_EN_POS];
        sj_ff <= sfr_wdata[`SJ_MSB:`SJ_LSB];
        rpt_ff <= sfr_wdata[`RPT_MSB:`RPT_LSB];
      end
      if (wr_pwr) begin
        lp_ff <= sfr_wdata[`LP_POS];
        pwr_ff <= sfr_wdata[`PWR_MSB:`PWR_LSB];
      end
      // only the track field is stored
      if (wr_trk) begin
        trk_ff <= sfr_wdata[`TRK_MSB:`TRK_LSB];
      end
    end
  end

  assign twelve_bit_enable = twelve_ff;
  assign low_power_select = lp_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Conversion sequencer

  assign conv_end = (state_ff == ST_CONV) && sar_done;

  always @* begin
    nxt_state = state_ff;
    nxt_cnt = cnt_ff;
    nxt_sar_cnt = sar_cnt_ff;
    nxt_remain = remain_ff;
    nxt_start = 1'b0;
    case (state_ff)
      ST_IDLE: begin
        if (start_conversion) begin
          nxt_remain = burst_enable ? burst_len : 7'h01;
          nxt_sar_cnt = `TM_EXTRA_SAR;
          if (burst_enable && !converter_enable) begin
            // wake the core before the first sample
            nxt_state = ST_PWRUP;
            nxt_cnt = pwrup_cycles[7:0] - 8'h01;
          end else if (burst_enable || converter_enable) begin
            // first sample skips the programmed track time
            if (delayed_track_select) begin
              nxt_state = ST_TMDLY;
            end else begin
              nxt_state = ST_CONV;
              nxt_start = 1'b1;
            end
          end
        end
      end
      ST_PWRUP: begin
        if (cnt_ff == 8'h00) begin
          if (delayed_track_select) begin
            nxt_state = ST_TMDLY;
          end else begin
            nxt_state = ST_CONV;
            nxt_start = 1'b1;
          end
        end else begin
          nxt_cnt = cnt_ff - 8'h01;
        end
      end
      ST_TRACK: begin
        if (cnt_ff == 8'h00) begin
          if (delayed_track_select) begin
            nxt_state = ST_TMDLY;
            nxt_sar_cnt = `TM_EXTRA_SAR;
          end else begin
            nxt_state = ST_CONV;
            nxt_start = 1'b1;
          end
        end else begin
          nxt_cnt = cnt_ff - 8'h01;
        end
      end
      ST_TMDLY: begin
        // three extra converter clocks of tracking
        if (sar_clk_en) begin
          if (sar_cnt_ff == 2'h1) begin
            nxt_state = ST_CONV;
            nxt_start = 1'b1;
          end
          nxt_sar_cnt = sar_cnt_ff - 2'h1;
        end
      end
      ST_CONV: begin
        if (sar_done) begin
          nxt_remain = remain_ff - 7'h01;
          if (remain_ff > 7'h01) begin
            nxt_state = ST_TRACK;
            nxt_cnt = track_cycles[7:0] - 8'h01;
          end else begin
            nxt_state = ST_IDLE;
          end
        end
      end
      default: nxt_state = ST_IDLE;
    endcase
  end

  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_ff <= ST_IDLE;
      cnt_ff <= 8'h00;
      sar_cnt_ff <= 2'h0;
      remain_ff <= 7'h00;
      start_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      cnt_ff <= nxt_cnt;
      sar_cnt_ff <= nxt_sar_cnt;
      remain_ff <= nxt_remain;
      start_ff <= nxt_start;
    end
  end

  assign sar_start = start_ff;
  assign busy = (state_ff != ST_IDLE);

  // powered only while a burst runs when disabled
  assign sar_power_on = converter_enable || (burst_enable && (state_ff != ST_IDLE));

  ////////////////////////////////////////////////////////////////////////////
  // Accumulator and complete flag

  always @* begin
    nxt_acc = acc_ff;
    // Burst without accumulate starts its sum from zero
    if ((state_ff == ST_IDLE) && start_conversion && burst_enable && !acc_en_ff) begin
      nxt_acc = 16'h0000;
    end
    if (conv_end) begin
      if (burst_enable || acc_en_ff) begin
        nxt_acc = acc_ff + sample_ext;
      end else begin
        nxt_acc = sample_ext;
      end
    end
    // software writes load the accumulator, winning over a sample
    if (wr_lo) begin
      nxt_acc[7:0] = sfr_wdata;
    end
    if (wr_hi) begin
      nxt_acc[15:8] = sfr_wdata;
    end
  end

  // flag per conversion or per burst
  assign flag_set = conv_end && (remain_ff == 7'h01);

  always @* begin
    nxt_flag = flag_ff;
    if (flag_clear) begin
      nxt_flag = 1'b0;
    end
    // A completion in the clearing cycle is kept
    if (flag_set) begin
      nxt_flag = 1'b1;
    end
  end

  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      acc_ff <= 16'h0000;
      flag_ff <= 1'b0;
    end else begin
      acc_ff <= nxt_acc;
      flag_ff <= nxt_flag;
    end
  end

  assign conversion_complete_flag = flag_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Read path

  result_formatter u_fmt (
    .acc(acc_ff),
    .shift_justify_select(sj_ff),
    .twelve_bit_enable(twelve_ff),
    .formatted(formatted)
  );

  always @* begin
    nxt_rdata = rdata_ff;
    if (sfr_rd) begin
      case (sfr_addr)
        `ACC_CFG_ADDR: nxt_rdata = {twelve_ff, 1'b0, sj_ff, rpt_ff};
        `PWR_TIME_ADDR: nxt_rdata = {lp_ff, 3'h0, pwr_ff};
        // reserved and unused bits read zero
        `TRK_TIME_ADDR: nxt_rdata = {2'h0, trk_ff};
        `RES_LOW_ADDR: nxt_rdata = formatted[7:0];
        `RES_HIGH_ADDR: nxt_rdata = formatted[15:8];
        default: nxt_rdata = 8'h00;
      endcase
    end
  end

  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_ff <= 8'h00;
    end else begin
      rdata_ff <= nxt_rdata;
    end
  end

  assign sfr_rdata = rdata_ff;

endmodule // adc_burst_accumulate_control

// ### tb/adc_burst_asserts.sv
// Port-level assertions for the burst accumulate controller
`timescale 1ns/1ps
`include "adc_burst_map.vh"
module adc_burst_asserts #(parameter RES_W = 12) (
  input wire ref_clk,
  input wire rst_n,
  input wire [7:0] sfr_addr,
  input wire [7:0] sfr_wdata,
  input wire sfr_wr,
  input wire sfr_rd,
  input wire [7:0] sfr_rdata,
  input wire converter_enable,
  input wire burst_enable,
  input wire delayed_track_select,
  input wire start_conversion,
  input wire flag_clear,
  input wire sar_clk_en,
  input wire sar_done,
  input wire [RES_W-1:0] sar_result,
  input wire conversion_complete_flag,
  input wire sar_power_on,
  input wire sar_start,
  input wire twelve_bit_enable,
  input wire low_power_select,
  input wire busy
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  a_twelve_bit_wr: assert property (sfr_wr && sfr_addr == `ACC_CFG_ADDR
    |=> twelve_bit_enable == $past(sfr_wdata[7])) else $error("twelve bit not loaded");
  a_acc_en_rd: assert property (sfr_rd && sfr_addr == `ACC_CFG_ADDR
    |=> !sfr_rdata[6]) else $error("accumulate bit read back");
  a_low_power_wr: assert property (sfr_wr && sfr_addr == `PWR_TIME_ADDR
    |=> low_power_select == $past(sfr_wdata[7])) else $error("low power not loaded");
  a_trk_rsvd_rd: assert property (sfr_rd && sfr_addr == `TRK_TIME_ADDR
    |=> sfr_rdata[7:6] == 2'h0) else $error("track top bits not zero");
  a_power_no_burst: assert property (!burst_enable
    |-> sar_power_on == converter_enable) else $error("power not following enable");
  a_power_kept_on: assert property (burst_enable && converter_enable
    |-> sar_power_on) else $error("power dropped in burst");
  a_sleep_after_burst: assert property (burst_enable && !converter_enable && !busy
    |-> !sar_power_on) else $error("power held after burst");
  a_start_at_once: assert property (start_conversion && !busy && converter_enable
    && !delayed_track_select |=> sar_start) else $error("start not immediate");
  a_powerup_wait: assert property (start_conversion && !busy && burst_enable
    && !converter_enable |=> !sar_start [*8]) else $error("start before power-up");
  a_flag_single: assert property (sar_done && busy && !burst_enable
    |=> conversion_complete_flag) else $error("flag not set");
  a_flag_held: assert property (conversion_complete_flag && !flag_clear
    |=> conversion_complete_flag) else $error("flag dropped");
endmodule // adc_burst_asserts

bind adc_burst_accumulate_control adc_burst_asserts #(.RES_W(RES_W)) u_chk (
  .ref_clk, .rst_n, .sfr_addr, .sfr_wdata, .sfr_wr, .sfr_rd, .sfr_rdata,
  .converter_enable, .burst_enable, .delayed_track_select, .start_conversion,
  .flag_clear, .sar_clk_en, .sar_done, .sar_result, .conversion_complete_flag,
  .sar_power_on, .sar_start, .twelve_bit_enable, .low_power_select, .busy);

// ### tb/sar_core_model.sv
// Behavioural converter core with fixed conversion latency
`timescale 1ns/1ps
module sar_core_model #(parameter LAT = 6) (
  input wire ref_clk,
  input wire sar_start,
  input wire sar_power_on,
  input wire [11:0] val,
  output reg sar_done = 1'b0,
  output reg [11:0] sar_result = 12'h000,
  output reg sar_clk_en = 1'b0
);
  int cnt = 0;
  int div = 0;
  always @(posedge ref_clk) begin
    div <= (div + 1) % 4;
    sar_clk_en <= (div == 3);
    sar_done <= (cnt == 1);
    // Outside a result the lines show garbage, never a stale copy
    sar_result <= (cnt == 1) ? val : ~val;
    // An unpowered core ignores its start
    if (sar_start && sar_power_on) cnt <= LAT;
    else if (cnt != 0) cnt <= cnt - 1;
  end
endmodule // sar_core_model

// ### tb/tb_top.sv
// Register, formatting and burst sequencing tests
`timescale 1ns/1ps
module tb_top;
  logic ref_clk = 0, rst_n = 0, sfr_wr = 0, sfr_rd = 0, converter_enable = 0;
  logic burst_enable = 0, delayed_track_select = 0, start_conversion = 0, flag_clear = 0;
  logic [7:0] sfr_addr = 8'h00, sfr_wdata = 8'h00;
  logic [11:0] val = 12'h000;
  wire [7:0] sfr_rdata;
  wire [11:0] sar_result;
  wire sar_clk_en, sar_done, conversion_complete_flag, sar_power_on, sar_start;
  wire twelve_bit_enable, low_power_select, busy;
  int miscompares = 0, check_count = 0, cyc = 0, n_go, t_go, t_done, first_d, gap;
  always #25 ref_clk = ~ref_clk;
  adc_burst_accumulate_control #(.RES_W(12)) dut (.ref_clk, .rst_n, .sfr_addr,
    .sfr_wdata, .sfr_wr, .sfr_rd, .sfr_rdata, .converter_enable, .burst_enable,
    .delayed_track_select, .start_conversion, .flag_clear, .sar_clk_en, .sar_done,
    .sar_result, .conversion_complete_flag, .sar_power_on, .sar_start,
    .twelve_bit_enable, .low_power_select, .busy);
  sar_core_model core (.ref_clk, .sar_start, .sar_power_on, .val, .sar_done,
    .sar_result, .sar_clk_en);
  ////////////////////////////////////////
  // Timestamps of starts and completions; also the hang limit
  always @(posedge ref_clk) begin
    cyc++;
    if (sar_done) t_done = cyc;
    if (sar_start) begin
      if (n_go == 0) first_d = cyc - t_go;
      else gap = cyc - t_done;
      n_go++;
    end
    if (cyc > 20000) begin
      miscompares++;
      results();
    end
  end
  task automatic results;
    $display("checks %0d miscompares %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic check(input string nm, input logic [15:0] seen, exp);
    check_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic tick(input int n = 1);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  // A strobe stays low for one edge so no signal changes twice at once
  task automatic wr(input logic [7:0] a, d);
    sfr_addr = a;
    sfr_wdata = d;
    sfr_wr = 1;
    tick();
    sfr_wr = 0;
    tick();
  endtask
  task automatic rd(input logic [7:0] a, e);
    sfr_addr = a;
    sfr_rd = 1;
    tick();
    sfr_rd = 0;
    check($sformatf("reg %h", a), {8'h00, sfr_rdata}, {8'h00, e});
    tick();
  endtask
  task automatic res(input logic [15:0] e);
    rd(8'hbd, e[7:0]);
    rd(8'hbe, e[15:8]);
  endtask
  task automatic conv(input logic [11:0] v);
    val = v;
    n_go = 0;
    t_go = cyc;
    start_conversion = 1;
    tick();
    start_conversion = 0;
    for (int i = 0; i < 5000 && conversion_complete_flag !== 1'b1; i++) tick();
    check("flag", {15'h0, conversion_complete_flag}, 16'h0001);
    check("busy", {15'h0, busy}, 16'h0000);
    flag_clear = 1;
    tick();
    flag_clear = 0;
  endtask
  ////////////////////////////////////////
  initial begin
    tick(3);
    rst_n = 1;
    rd(8'hba, 8'h00);
    rd(8'hbb, 8'h0f);
    rd(8'hbc, 8'h1e);
    rd(8'hbf, 8'h00);
    res(16'h0000);
    wr(8'hba, 8'hc0);
    rd(8'hba, 8'h80);
    check("twelve", {15'h0, twelve_bit_enable}, 16'h0001);
    wr(8'hbb, 8'hff);
    rd(8'hbb, 8'h8f);
    check("lowpwr", {15'h0, low_power_select}, 16'h0001);
    wr(8'hbc, 8'h7f);
    rd(8'hbc, 8'h3f);
    $display("end registers");
    converter_enable = 1;
    wr(8'hba, 8'h00);
    conv(12'h123);
    res(16'h0123);
    conv(12'h456);
    res(16'h0456);
    wr(8'hba, 8'h40);
    conv(12'h100);
    res(16'h0556);
    wr(8'hbd, 8'h00);
    wr(8'hbe, 8'h00);
    res(16'h0000);
    $display("end single");
    wr(8'hbe, 8'h0a);
    wr(8'hbd, 8'hbc);
    for (int k = 0; k < 4; k++) begin
      wr(8'hba, {2'b00, k[2:0], 3'b000});
      res(16'h0abc >> k);
    end
    wr(8'hba, 8'ha0);
    res(16'habc0);
    wr(8'hba, 8'h20);
    res(16'haf00);
    $display("end format");
    wr(8'hbb, 8'h01);
    wr(8'hbc, 8'h3c);
    burst_enable = 1;
    converter_enable = 0;
    // Repeat count is only raised once burst is on
    wr(8'hba, 8'h01);
    conv(12'h0a5);
    check("sleep", {15'h0, sar_power_on}, 16'h0000);
    check("pwrup", 16'(first_d >= 18 && first_d <= 20), 16'h0001);
    check("track", 16'(gap >= 4 && gap <= 6), 16'h0001);
    check("count", 16'(n_go), 16'h0004);
    res(16'h0294);
    converter_enable = 1;
    for (int r = 0; r < 6; r++) begin
      wr(8'hba, {5'h00, r[2:0]});
      conv(12'h0a5);
      check("count", 16'(n_go), 16'(r ? 2 << r : 1));
      check("first", 16'(first_d), 16'h0002);
    end
    res(16'h2940);
    converter_enable = 0;
    wr(8'hbb, 8'h04);
    wr(8'hba, 8'h00);
    conv(12'h0a5);
    check("pwrup", 16'(first_d), 16'h002a);
    converter_enable = 1;
    delayed_track_select = 1;
    wr(8'hba, 8'h00);
    conv(12'h0a5);
    check("dtrack", 16'(first_d >= 11 && first_d <= 16), 16'h0001);
    $display("end burst");
    results();
  end
endmodule // tb_top
